// ### logic/exc_vec_map.svh
// offsets, field positions, reset values, vector numbers and timing counts
`ifndef EXC_VEC_MAP_SVH
`define EXC_VEC_MAP_SVH

`define TMR_MCR_OFS 16'hf900
`define TMR_ICR_OFS 16'hf904
`define MOD_STRIDE 16'h0040
`define STATUS_OFS 16'hf9f0

`define MCR_ARB_LSB 0
`define ICR_HP_LSB 0
`define ICR_BASE_LSB 4
`define ICR_LVL_LSB 8

`define MCR_ARB_RST 4'h0
`define ICR_HP_RST 4'h0
`define ICR_BASE_RST 4'h0
`define ICR_LVL_RST 3'h0

`define VEC_RESET_BANKS 8'h00
`define VEC_FIRST_EXC 8'h04
`define VEC_UNINIT 8'h0f
`define VEC_AUTO_BASE 8'h10
`define VEC_SPURIOUS 8'h18
`define VEC_FIRST_USER 8'h38
`define MIN_USER_BASE 4'h4
`define RESET_WORDS 2'h3

`define CLK_PERIOD_NS 100
`define ACK_TIMEOUT_NS 1600
`define ACK_TIMEOUT_CYC ((`ACK_TIMEOUT_NS) / (`CLK_PERIOD_NS))

`endif

// ### logic/exc_vec_pkg.sv
// types shared by the exception vector dispatch logic
package exc_vec_pkg;
   typedef enum logic [2:0] {
      s_fetch,
      s_fetch_strobe,
      s_fetch_load,
      s_idle,
      s_ack
   } dispatch_state_t;
endpackage

// ### logic/exception_vector_dispatch.sv
// exception vector dispatch: reset fetch, fixed vectors, arbitration and acknowledge
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps
`include "exc_vec_map.svh"
module exception_vector_dispatch #(
   parameter int N_MOD = 2,
   parameter logic [3:0] EXT_ARB = 4'h0
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [15:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [N_MOD-1:0] mod_req_n,
   input wire logic [7:1] ext_irq_n,
   input wire logic internal_ack_line,
   input wire logic [3:0] ack_src,
   input wire logic autovector_response_n,
   input wire logic ext_vec_valid,
   input wire logic [7:0] ext_vec,
   input wire logic [4:0] exc_req,
   input wire logic [2:0] ipl_mask,
   input wire logic [15:0] mem_data,
   output logic mem_rd,
   output logic mem_prog,
   output logic [8:0] mem_addr,
   output logic [15:0] ext_banks,
   output logic [15:0] init_pc,
   output logic [15:0] init_sp,
   output logic [15:0] direct_page_index,
   output logic reset_done,
   output logic irq_pending,
   output logic [2:0] irq_level,
   output logic iack_cycle,
   output logic [2:0] iack_level,
   output logic [3:0] iack_arb,
   output logic vec_valid,
   output logic [7:0] vec_num,
   output logic [8:0] vec_addr,
   output exc_vec_pkg::dispatch_state_t state
);
   import exc_vec_pkg::*;

   localparam int MW = (N_MOD > 1) ? $clog2(N_MOD) : 1;
   localparam int TIMEOUT = `ACK_TIMEOUT_CYC;

   logic [3:0] arb_q [N_MOD];
   logic [2:0] lvl_q [N_MOD];
   logic [3:0] base_q [N_MOD];
   logic [3:0] hp_q [N_MOD];
   logic [15:0] next_rdata;
   logic [1:0] fetch_idx;
   logic [7:0] ack_cnt;
   logic win_int;
   logic [MW-1:0] win_mod;
   logic best_hit;
   logic best_int;
   logic [MW-1:0] best_mod;
   logic [2:0] best_lvl;
   logic [3:0] best_arb;
   logic [7:0] exc_num;
   logic ack_timeout;

   // unassigned or reset bases give the uninitialized vector
   function automatic logic [7:0] module_vector(input logic [3:0] base, input logic [3:0] hp,
                                                input logic [3:0] src);
      logic [7:0] ofs;
      ofs = (src == hp) ? 8'h00 : {4'h0, src} + 8'h01;
      if (base < `MIN_USER_BASE)
         return `VEC_UNINIT;
      return {base, 4'h0} + ofs;
   endfunction

   // per-module configuration registers, strided from the timer's pair
   for (genvar k = 0; k < N_MOD; k++)
   begin : g_mod
      localparam logic [15:0] MCR_A = 16'(`TMR_MCR_OFS + k * `MOD_STRIDE);
      localparam logic [15:0] ICR_A = 16'(`TMR_ICR_OFS + k * `MOD_STRIDE);
      always_ff @(posedge ref_clk or posedge rst)
      begin
         if (rst)
         begin
            arb_q[k] <= `MCR_ARB_RST;
            lvl_q[k] <= `ICR_LVL_RST;
            base_q[k] <= `ICR_BASE_RST;
            hp_q[k] <= `ICR_HP_RST;
         end
         else if (reg_wr && reg_addr == MCR_A)
            arb_q[k] <= reg_wdata[`MCR_ARB_LSB +: 4];
         else if (reg_wr && reg_addr == ICR_A)
         begin
            lvl_q[k] <= reg_wdata[`ICR_LVL_LSB +: 3];
            base_q[k] <= reg_wdata[`ICR_BASE_LSB +: 4];
            hp_q[k] <= reg_wdata[`ICR_HP_LSB +: 4];
         end
      end
   end

   always_comb
   begin
      next_rdata = 16'h0000;
      if (reg_rd && reg_addr == `STATUS_OFS)
         next_rdata = {vec_num, reset_done, iack_cycle, 2'h0, irq_pending, irq_level};
      for (int k = 0; k < N_MOD; k++)
      begin
         if (reg_rd && reg_addr == 16'(`TMR_MCR_OFS + k * `MOD_STRIDE))
            next_rdata = {12'h000, arb_q[k]};
         if (reg_rd && reg_addr == 16'(`TMR_ICR_OFS + k * `MOD_STRIDE))
            next_rdata = {5'h00, lvl_q[k], base_q[k], hp_q[k]};
      end
   end

   // read data stand for one cycle only; unmapped reads return zero
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         reg_rdata <= 16'h0000;
      else
         reg_rdata <= next_rdata;
   end

   // highest level wins, arbitration only splits equal levels
   always_comb
   begin
      best_hit = 1'b0;
      best_int = 1'b0;
      best_mod = '0;
      best_lvl = 3'h0;
      best_arb = 4'h0;
      for (int k = 0; k < N_MOD; k++)
      begin
         if (!mod_req_n[k] && lvl_q[k] != 3'h0
             && (lvl_q[k] > ipl_mask || lvl_q[k] == 3'h7)
             && (!best_hit || {lvl_q[k], arb_q[k]} > {best_lvl, best_arb}))
         begin
            best_hit = 1'b1;
            best_int = 1'b1;
            best_mod = MW'(k);
            best_lvl = lvl_q[k];
            best_arb = arb_q[k];
         end
      end
      for (int l = 1; l < 8; l++)
      begin
         if (!ext_irq_n[l] && (3'(l) > ipl_mask || l == 7)
             && (!best_hit || {3'(l), EXT_ARB} > {best_lvl, best_arb}))
         begin
            best_hit = 1'b1;
            best_int = 1'b0;
            best_mod = '0;
            best_lvl = 3'(l);
            best_arb = EXT_ARB;
         end
      end
   end

   // lowest index is the most urgent fixed exception
   always_comb
   begin
      exc_num = `VEC_FIRST_EXC;
      for (int i = 4; i >= 0; i--)
         if (exc_req[i])
            exc_num = `VEC_FIRST_EXC + 8'(i);
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         irq_pending <= 1'b0;
         irq_level <= 3'h0;
      end
      else
      begin
         irq_pending <= best_hit;
         irq_level <= best_lvl;
      end
   end

   // acknowledge wait is bounded so a vanished source cannot hang the bus
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
         ack_cnt <= 8'h00;
      else if (state == s_ack)
         ack_cnt <= ack_cnt + 8'h01;
      else
         ack_cnt <= 8'h00;
   end
   assign ack_timeout = (ack_cnt == 8'(TIMEOUT - 1));

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         state <= s_fetch;
         fetch_idx <= 2'h0;
         mem_rd <= 1'b0;
         mem_prog <= 1'b0;
         mem_addr <= 9'h000;
         ext_banks <= 16'h0000;
         init_pc <= 16'h0000;
         init_sp <= 16'h0000;
         direct_page_index <= 16'h0000;
         reset_done <= 1'b0;
         iack_cycle <= 1'b0;
         iack_level <= 3'h0;
         iack_arb <= 4'h0;
         win_int <= 1'b0;
         win_mod <= '0;
         vec_valid <= 1'b0;
         vec_num <= 8'h00;
         vec_addr <= 9'h000;
      end
      else
      begin
         vec_valid <= 1'b0;
         unique case (state)
            s_fetch:
            begin
               mem_rd <= 1'b1;
               mem_prog <= 1'b1;
               mem_addr <= {6'h00, fetch_idx, 1'b0} + {1'b0, `VEC_RESET_BANKS};
               state <= s_fetch_strobe;
            end
            s_fetch_strobe:
            begin
               mem_rd <= 1'b0;
               state <= s_fetch_load;
            end
            s_fetch_load:
            begin
               unique case (fetch_idx)
                  2'h0: ext_banks <= mem_data;
                  2'h1: init_pc <= mem_data;
                  2'h2: init_sp <= mem_data;
                  2'h3: direct_page_index <= mem_data;
               endcase
               mem_prog <= 1'b0;
               fetch_idx <= fetch_idx + 2'h1;
               if (fetch_idx == `RESET_WORDS)
               begin
                  reset_done <= 1'b1;
                  state <= s_idle;
               end
               else
                  state <= s_fetch;
            end
            s_idle:
            begin
               if (exc_req != 5'h00)
               begin
                  vec_valid <= 1'b1;
                  vec_num <= exc_num;
                  vec_addr <= {exc_num, 1'b0};
               end
               else if (best_hit && !vec_valid)
               begin
                  iack_cycle <= 1'b1;
                  iack_level <= best_lvl;
                  iack_arb <= best_arb;
                  win_int <= best_int;
                  win_mod <= best_mod;
                  state <= s_ack;
               end
            end
            s_ack:
            begin
               if (win_int && internal_ack_line)
               begin
                  vec_num <= module_vector(base_q[win_mod], hp_q[win_mod], ack_src);
                  vec_addr <= {module_vector(base_q[win_mod], hp_q[win_mod], ack_src), 1'b0};
               end
               else if (!win_int && !internal_ack_line && !autovector_response_n)
               begin
                  vec_num <= `VEC_AUTO_BASE + {5'h00, iack_level};
                  vec_addr <= {`VEC_AUTO_BASE + {5'h00, iack_level}, 1'b0};
               end
               else if (!win_int && !internal_ack_line && ext_vec_valid)
               begin
                  vec_num <= (ext_vec < `VEC_FIRST_USER) ? `VEC_UNINIT : ext_vec;
                  vec_addr <= {((ext_vec < `VEC_FIRST_USER) ? `VEC_UNINIT : ext_vec), 1'b0};
               end
               else
               begin
                  vec_num <= `VEC_SPURIOUS;
                  vec_addr <= {`VEC_SPURIOUS, 1'b0};
               end
               if (internal_ack_line || !autovector_response_n || ext_vec_valid || ack_timeout)
               begin
                  vec_valid <= 1'b1;
                  iack_cycle <= 1'b0;
                  state <= s_idle;
               end
            end
         endcase
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);

   sequence fetch_word(logic [8:0] a);
      mem_rd && mem_prog && mem_addr == a;
   endsequence
   sequence ext_answer;
      iack_cycle && !win_int && !internal_ack_line && !autovector_response_n;
   endsequence

   vector_address_a: assert property (vec_valid |-> vec_addr == {vec_num, 1'b0})
      else $error("vector address is not twice the vector number");
   reset_order_a: assert property (fetch_word(9'h000) |-> ##3 fetch_word(9'h002) ##3
      fetch_word(9'h004) ##3 fetch_word(9'h006))
      else $error("reset words not fetched in order");
   fixed_exc_a: assert property (state == s_idle && exc_req[0] |=>
      vec_valid && vec_num == 8'h04)
      else $error("breakpoint did not give vector 4");
   autovector_num_a: assert property (ext_answer |=> vec_valid
      && vec_num == 8'h10 + {5'h00, $past(iack_level)})
      else $error("autovector number wrong");
   spurious_vec_a: assert property (iack_cycle && ack_timeout && !internal_ack_line
      && autovector_response_n && !ext_vec_valid |=> vec_valid && vec_num == 8'h18)
      else $error("timeout did not give spurious vector");
   ack_wait_a: assert property (iack_cycle && !internal_ack_line && autovector_response_n
      && !ext_vec_valid && !ack_timeout |=> iack_cycle && !vec_valid)
      else $error("acknowledge ended without an answer");
   uninit_vec_a: assert property (iack_cycle && win_int && internal_ack_line
      && base_q[win_mod] == 4'h0 |=> vec_num == 8'h0f)
      else $error("unprogrammed module did not give vector 15");
   user_base_a: assert property (iack_cycle && win_int && internal_ack_line
      && base_q[win_mod] == 4'h5 && ack_src == hp_q[win_mod] |=> vec_num == 8'h50)
      else $error("module base 5 did not give vector 50 hex");
   level_seven_a: assert property (!ext_irq_n[7] |=> irq_pending && irq_level == 3'h7)
      else $error("level 7 request not top priority");
   level_zero_a: assert property (irq_pending |-> irq_level != 3'h0)
      else $error("level 0 source raised a request");
endmodule

// ### verification/irq_source_model.sv
// far-side model: requesting on-chip modules and external devices
`timescale 1ns/1ps
module irq_source_model #(
   parameter int N_MOD = 2
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic [N_MOD-1:0] raise_mod,
   input wire logic [7:1] raise_ext,
   input wire logic [1:0] ans_kind,
   input wire logic [3:0] ans_src,
   input wire logic [7:0] ans_vec,
   input wire logic [3:0] ans_delay,
   input wire logic iack_cycle,
   input wire logic vec_valid,
   output logic [N_MOD-1:0] mod_req_n,
   output logic [7:1] ext_irq_n,
   output logic internal_ack_line,
   output logic [3:0] ack_src,
   output logic autovector_response_n,
   output logic ext_vec_valid,
   output logic [7:0] ext_vec
);
   logic [3:0] cnt;
   logic done, drive;
   logic [7:0] junk;
   // lines stay low until the next vector is delivered
   always_ff @(posedge ref_clk or posedge rst)
      if (rst)
      begin
         mod_req_n <= '1;
         ext_irq_n <= '1;
      end
      else
      begin
         mod_req_n <= vec_valid ? '1 : mod_req_n & ~raise_mod;
         ext_irq_n <= vec_valid ? '1 : ext_irq_n & ~raise_ext;
      end
   // answer after ans_delay cycles; kind 0 never answers
   always_ff @(posedge ref_clk or posedge rst)
      if (rst)
      begin
         cnt <= 4'h0;
         done <= 1'b0;
         drive <= 1'b0;
      end
      else if (!iack_cycle)
      begin
         cnt <= 4'h0;
         done <= 1'b0;
         drive <= 1'b0;
      end
      else if (drive)
      begin
         drive <= 1'b0;
         done <= 1'b1;
      end
      else if (!done && ans_kind != 2'h0 && cnt == ans_delay)
         drive <= 1'b1;
      else
         cnt <= cnt + 4'h1;
   // released lines carry a changing pattern, not the last value
   always_ff @(posedge ref_clk or posedge rst)
      if (rst)
         junk <= 8'h00;
      else
         junk <= junk + 8'h35;
   assign internal_ack_line = drive && ans_kind == 2'h1;
   assign autovector_response_n = !(drive && ans_kind == 2'h2);
   assign ext_vec_valid = drive && ans_kind == 2'h3;
   assign ack_src = drive ? ans_src : junk[3:0];
   assign ext_vec = drive ? ans_vec : junk;
endmodule

// ### verification/tb_exception_vector_dispatch.sv
// self-checking bench for the exception vector dispatch block
`timescale 1ns/1ps
module tb_exception_vector_dispatch;
   import exc_vec_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [15:0] reg_addr = 16'h0, reg_wdata = 16'h0, mem_data = 16'h0, reg_rdata;
   logic [1:0] raise_mod = 2'h0, ans_kind = 2'h0, mod_req_n;
   logic [7:1] raise_ext = 7'h0, ext_irq_n;
   logic [3:0] ans_src = 4'h0, ans_delay = 4'h0, ack_src, iack_arb, arb_seen;
   logic [7:0] ans_vec = 8'h0, ext_vec, vec_num;
   logic [4:0] exc_req = 5'h0;
   logic [2:0] ipl_mask = 3'h0, irq_level, iack_level, lvl_seen;
   logic internal_ack_line, autovector_response_n, ext_vec_valid, mem_rd, mem_prog;
   logic reset_done, irq_pending, iack_cycle, vec_valid;
   logic [8:0] mem_addr, vec_addr;
   logic [15:0] ext_banks, init_pc, init_sp, direct_page_index;
   logic [15:0] rom [4];
   dispatch_state_t state;
   int err_count = 0, total_checks = 0, fetch_idx = 0, cycles = 0;
   exception_vector_dispatch exception_vector_dispatch_i (.ref_clk, .rst, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .mod_req_n, .ext_irq_n, .internal_ack_line,
      .ack_src, .autovector_response_n, .ext_vec_valid, .ext_vec, .exc_req, .ipl_mask,
      .mem_data, .mem_rd, .mem_prog, .mem_addr, .ext_banks, .init_pc, .init_sp,
      .direct_page_index, .reset_done, .irq_pending, .irq_level, .iack_cycle, .iack_level,
      .iack_arb, .vec_valid, .vec_num, .vec_addr, .state);
   irq_source_model irq_source_model_i (.ref_clk, .rst, .raise_mod, .raise_ext, .ans_kind,
      .ans_src, .ans_vec, .ans_delay, .iack_cycle, .vec_valid, .mod_req_n, .ext_irq_n,
      .internal_ack_line, .ack_src, .autovector_response_n, .ext_vec_valid, .ext_vec);
   always #50 ref_clk = ~ref_clk;
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   // program memory: word answers the cycle after the strobe
   always @(posedge ref_clk)
   begin
      if (mem_rd === 1'b1)
      begin
         check("fetch", {mem_prog, 6'h0, mem_addr}, {7'h40, 9'(fetch_idx * 2)});
         fetch_idx++;
      end
      mem_data <= (mem_rd === 1'b1) ? rom[mem_addr[2:1]] : ~mem_data;
   end
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         err_count++;
         report_and_stop();
      end
   end
   // returns in the edge step: drives land on the edge, reads see last cycle's values
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // strobe drops one edge before the task returns, so no signal is driven twice in a step
   task automatic wr(input logic [15:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
      @(posedge ref_clk);
   endtask
   // read data stand only in the cycle after the strobe; taken at that cycle's closing edge
   task automatic rd(input logic [15:0] a, output logic [15:0] q);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      @(posedge ref_clk);
      q = reg_rdata;
   endtask
   task automatic raise(input logic [1:0] m, input logic [7:1] e);
      raise_mod <= m;
      raise_ext <= e;
      cyc(1);
      raise_mod <= 2'h0;
      raise_ext <= 7'h0;
   endtask
   task automatic wait_vec(input logic [7:0] exp, output int n);
      n = 0;
      while (vec_valid !== 1'b1 && n < 60)
      begin
         if (iack_cycle === 1'b1)
         begin
            lvl_seen = iack_level;
            arb_seen = iack_arb;
         end
         cyc(1);
         n++;
      end
      check("valid", 16'(vec_valid), 16'h1);
      check("vec", 16'(vec_num), 16'(exp));
      check("addr", 16'(vec_addr), {7'h0, exp, 1'b0});
      cyc(1);
   endtask
   function automatic logic [7:0] mod_vec(input logic [3:0] b, h, s);
      if (b < 4'h4)
         return 8'h0f;
      return {b, 4'h0} + ((s == h) ? 8'h00 : 8'(s) + 8'h01);
   endfunction
   initial
   begin
      logic [15:0] q;
      logic [3:0] b, h, s;
      logic [7:0] v;
      int n;
      void'($urandom(52));
      foreach (rom[i])
         rom[i] = 16'($urandom);
      repeat (10) @(posedge ref_clk);
      rst <= 1'b0;
      cyc(14);
      check("done", 16'(reset_done), 16'h1);
      check("state", 16'(state), 16'(s_idle));
      check("banks", ext_banks, rom[0]);
      check("pc", init_pc, rom[1]);
      check("sp", init_sp, rom[2]);
      check("page", direct_page_index, rom[3]);
      rd(16'hf904, q);
      check("icr", q, 16'h0);
      wr(16'hf904, 16'hffff);
      wr(16'hf900, 16'hffff);
      rd(16'hf904, q);
      check("icr", q, 16'h07ff);
      rd(16'hf900, q);
      check("mcr", q, 16'h000f);
      rd(16'hf9fe, q);
      check("unmapped", q, 16'h0);
      for (int i = 0; i < 6; i++)
      begin
         exc_req <= (i < 5) ? 5'(1 << i) : 5'h16;
         cyc(1);
         exc_req <= 5'h0;
         wait_vec((i < 5) ? 8'(4 + i) : 8'h05, n);
      end
      rd(16'hf9f0, q);
      check("status", q, 16'h0580);
      ans_kind <= 2'h2;
      for (int l = 1; l < 8; l++)
      begin
         ipl_mask <= 3'(l - 1);
         ans_delay <= 4'($urandom_range(3));
         raise(2'h0, 7'(1 << (l - 1)));
         wait_vec(8'(16 + l), n);
         check("lvl", 16'(lvl_seen), 16'(l));
      end
      ipl_mask <= 3'h3;
      raise(2'h0, 7'h04);
      cyc(6);
      check("masked", 16'(iack_cycle), 16'h0);
      ipl_mask <= 3'h2;
      wait_vec(8'h13, n);
      ipl_mask <= 3'h0;
      ans_kind <= 2'h3;
      for (int i = 0; i < 6; i++)
      begin
         v = (i == 0) ? 8'h37 : (i == 1) ? 8'h38 : 8'($urandom);
         ans_vec <= v;
         raise(2'h0, 7'h10);
         wait_vec((v < 8'h38) ? 8'h0f : v, n);
      end
      ans_kind <= 2'h1;
      for (int i = 0; i < 8; i++)
      begin
         b = (i == 0) ? 4'h5 : (i == 1) ? 4'h0 : 4'($urandom);
         h = 4'($urandom);
         s = (i == 0) ? h : 4'($urandom);
         ans_src <= s;
         ans_delay <= 4'($urandom_range(3));
         wr(16'hf904, {5'h0, 3'h6, b, h});
         raise(2'h1, 7'h0);
         wait_vec(mod_vec(b, h, s), n);
         check("mlvl", 16'(lvl_seen), 16'h6);
      end
      ans_kind <= 2'h2;
      raise(2'h1, 7'h0);
      wait_vec(8'h18, n);
      ans_kind <= 2'h0;
      raise(2'h1, 7'h0);
      wait_vec(8'h18, n);
      check("wait", 16'(n >= 16), 16'h1);
      ans_kind <= 2'h1;
      ans_src <= 4'h0;
      wr(16'hf904, 16'h0460);
      wr(16'hf944, 16'h0490);
      wr(16'hf900, 16'h0003);
      wr(16'hf940, 16'h0009);
      raise(2'h3, 7'h0);
      wait_vec(8'h90, n);
      check("arb", 16'(arb_seen), 16'h9);
      wr(16'hf904, 16'h0560);
      raise(2'h3, 7'h0);
      wait_vec(8'h60, n);
      check("lvl", 16'(lvl_seen), 16'h5);
      wr(16'hf944, 16'h0090);
      raise(2'h2, 7'h0);
      cyc(8);
      check("off", {14'h0, irq_pending, iack_cycle}, 16'h0);
      report_and_stop();
   end
endmodule
